// >>> rtl/adcsmc_regs.svh
`ifndef ADCSMC_REGS_SVH
`define ADCSMC_REGS_SVH
// Register select codes carried in the communications byte.
`define ADCSMC_SEL_COMMS        3'h0
`define ADCSMC_SEL_SETUP        3'h1
// Setup register reset value and field positions.
`define ADCSMC_SETUP_RESET      8'h01
`define ADCSMC_MODE_MSB         7
`define ADCSMC_MODE_LSB         6
`define ADCSMC_GAIN_MSB         5
`define ADCSMC_GAIN_LSB         3
`define ADCSMC_POL_BIT          2
`define ADCSMC_BUF_BIT          1
`define ADCSMC_HOLD_BIT         0
// Communications byte field positions.
`define ADCSMC_COM_ZERO_BIT     7
`define ADCSMC_COM_RS_MSB       6
`define ADCSMC_COM_RS_LSB       4
`define ADCSMC_COM_RD_BIT       3
`define ADCSMC_COM_CH_MSB       1
`define ADCSMC_COM_CH_LSB       0
// Filter settling is three output-update periods.
`define ADCSMC_SETTLE_PERIODS   2'h3
`endif

// >>> rtl/adcsmc_pkg.sv
package adcsmc_pkg;
    // Values of the operating mode field.
    typedef enum logic [1:0] {
        ADCSMC_MODE_NORMAL = 2'h0,
        ADCSMC_MODE_SELF   = 2'h1,
        ADCSMC_MODE_ZERO   = 2'h2,
        ADCSMC_MODE_FULL   = 2'h3
    } adcsmc_mode_t;

    // Settings handed to the analog front end.
    typedef struct packed {
        logic [7:0] gain_factor;
        logic       unipolar;
        logic       buffer_in;
        logic [1:0] channel_select;
        logic       noise_test;
        logic       hold_reset;
    } adcsmc_front_t;

    // Calibration step requests to the modulator side.
    typedef struct packed {
        logic busy;
        logic zero_scale;
        logic full_scale;
        logic internal_src;
    } adcsmc_cal_t;
endpackage

// >>> rtl/adcsmc_top.sv
// What this block does
// RULE1 - Setup register is eight bits, host may read and write it serially.
// RULE2 - Setup register has select code 001 and resets to 0x01.
// RULE3 - Layout: mode[7:6], gain[5:3], polarity, buffer, filter hold; hold resets one.
// RULE4 - Mode 00 runs continuous normal conversions on the selected channel.
// RULE5 - Mode 01 runs self-calibration, then clears mode to 00 and resumes.
// RULE6 - Self-cal zero point on shorted inputs, full point on reference over gain.
// RULE7 - Any calibration raises data-ready flag; lowers it when done with fresh result. A fresh result in the write cycle leaves it low instead.
// RULE8 - Mode 10 runs zero-scale system calibration, then mode returns to 00.
// RULE9 - Mode 11 runs full-scale system calibration, then mode returns to 00.
// RULE10 - Gain equals two raised to the three-bit gain code.
// RULE11 - Polarity bit clear is bipolar, set is unipolar.
// RULE12 - Buffer bit zero bypasses input buffer, one puts it in series.
// RULE13 - Filter hold set keeps filter, its control, calibration and modulator reset.
// RULE14 - After hold clears, first result comes after three update periods.
// RULE15 - Filter hold leaves serial port alone and does not raise a low flag.
// RULE16 - Channel-select bits steer work; code 10 shorts the common input.
// RULE17 - Writing a calibration code abandons conversion and starts calibration at once.
`include "adcsmc_regs.svh"
module adcsmc_top (
    // Clock and reset.
    input  wire logic                    clk_i,
    input  wire logic                    rst_n_i,
    // Three-wire serial port, sampled from outside the clock domain.
    input  wire logic                    sclk_i,
    input  wire logic                    din_i,
    input  wire logic                    cs_n_i,
    output logic                         dout_o,
    // Modulator side: update tick and step completion.
    input  wire logic                    update_tick_i,
    input  wire logic                    cal_step_done_i,
    // Front end settings and status.
    output adcsmc_pkg::adcsmc_front_t    front_o,
    output adcsmc_pkg::adcsmc_cal_t      cal_o,
    output logic                         convert_run_o,
    output logic                         result_valid_o,
    output logic                         result_pending_flag_n_o
);
    import adcsmc_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Reset release and input synchronisers.
    logic       rst_meta;
    logic       rst_n;
    logic [2:0] pin_meta;
    logic [2:0] pin_sync;
    logic       sclk_prev;
    // Every check at the foot of this file runs on this clock and the released reset.
    default clocking cb_main @(posedge clk_i); endclocking
    default disable iff (!rst_n);

    // Reset is released through two flops so every register leaves it together.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rst_meta <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n    <= rst_meta;
        end
    end

    // Pins pass two flops; only the second stage is looked at.
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            pin_meta  <= 3'h7;
            pin_sync  <= 3'h7;
            sclk_prev <= 1'b1;
        end else begin
            pin_meta  <= {cs_n_i, din_i, sclk_i};
            pin_sync  <= pin_meta;
            sclk_prev <= pin_sync[0];
        end
    end

    logic sclk_s;
    logic din_s;
    logic cs_n_s;
    logic sclk_rise;
    logic sclk_fall;
    assign sclk_s    = pin_sync[0];
    assign din_s     = pin_sync[1];
    assign cs_n_s    = pin_sync[2];
    assign sclk_rise = !cs_n_s && sclk_s && !sclk_prev;
    assign sclk_fall = !cs_n_s && !sclk_s && sclk_prev;

    ////////////////////////////////////////////////////////////////////////////
    // Serial shifter: a communications byte picks the next access.
    typedef enum logic [1:0] {SH_COMMS, SH_WRITE, SH_READ} sh_state_t;
    sh_state_t  sh_state;
    logic [2:0] bit_cnt;
    logic [7:0] shift_in;
    logic [7:0] shift_out;
    logic       setup_wr;
    logic [7:0] setup_wdata;
    logic [1:0] channel_select;
    logic [7:0] converter_setup;
    logic       result_pending_flag;
    logic [7:0] next_shift_in;
    assign next_shift_in = {shift_in[6:0], din_s};

    // Only the setup register and communications byte live here; other selects
    // are shifted through and dropped, and read back as zero.
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            sh_state       <= SH_COMMS;
            bit_cnt        <= 3'h0;
            shift_in       <= 8'h00;
            shift_out      <= 8'h00;
            setup_wr       <= 1'b0;
            setup_wdata    <= 8'h00;
            channel_select <= 2'h0;
        end else begin
            setup_wr <= 1'b0;
            if (sclk_fall && sh_state == SH_READ) begin
                shift_out <= {shift_out[6:0], 1'b0};
            end
            if (sclk_rise) begin
                shift_in <= next_shift_in;
                case (sh_state)
                    SH_COMMS: begin
                        // A leading one holds the port at the first bit.
                        if (bit_cnt == 3'h0 && din_s) begin
                            bit_cnt <= 3'h0;
                        end else if (bit_cnt == 3'h7) begin
                            bit_cnt        <= 3'h0;
                            channel_select <= next_shift_in[`ADCSMC_COM_CH_MSB:`ADCSMC_COM_CH_LSB]; // [RULE16]
                            if (next_shift_in[`ADCSMC_COM_RD_BIT]) begin
                                sh_state <= SH_READ;
                                if (next_shift_in[`ADCSMC_COM_RS_MSB:`ADCSMC_COM_RS_LSB]
                                        == `ADCSMC_SEL_SETUP) begin
                                    shift_out <= converter_setup; // [RULE1]
                                end else if (next_shift_in[`ADCSMC_COM_RS_MSB:`ADCSMC_COM_RS_LSB]
                                        == `ADCSMC_SEL_COMMS) begin
                                    shift_out <= {result_pending_flag, 7'h00};
                                end else begin
                                    shift_out <= 8'h00;
                                end
                            end else begin
                                sh_state <= SH_WRITE;
                            end
                            setup_wdata <= {5'h00,
                                next_shift_in[`ADCSMC_COM_RS_MSB:`ADCSMC_COM_RS_LSB]};
                        end else begin
                            bit_cnt <= bit_cnt + 3'h1;
                        end
                    end
                    SH_WRITE: begin
                        bit_cnt <= bit_cnt + 3'h1;
                        if (bit_cnt == 3'h7) begin
                            sh_state    <= SH_COMMS;
                            setup_wr    <= (setup_wdata[2:0] == `ADCSMC_SEL_SETUP); // [RULE2]
                            setup_wdata <= next_shift_in;
                        end
                    end
                    SH_READ: begin
                        bit_cnt <= bit_cnt + 3'h1;
                        if (bit_cnt == 3'h7) begin
                            sh_state <= SH_COMMS;
                        end
                    end
                    default: begin
                        sh_state <= SH_COMMS;
                    end
                endcase
            end
        end
    end

    // Output bit stands from the falling edge; idle high-low is zero.
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            dout_o <= 1'b0;
        end else begin
            dout_o <= (sh_state == SH_READ) ? shift_out[7] : 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Calibration sequencer.
    typedef enum logic [1:0] {CAL_IDLE, CAL_ZERO, CAL_FULL} cal_state_t;
    cal_state_t   cal_state;
    adcsmc_mode_t wr_mode;
    logic         cal_done;
    logic         hold;
    assign wr_mode = adcsmc_mode_t'(setup_wdata[`ADCSMC_MODE_MSB:`ADCSMC_MODE_LSB]);
    assign hold    = converter_setup[`ADCSMC_HOLD_BIT];

    // Held in reset while filter hold is set; a calibration write restarts it.
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            cal_state <= CAL_IDLE;
            cal_done  <= 1'b0;
        end else begin
            cal_done <= 1'b0;
            if (setup_wr && setup_wdata[`ADCSMC_HOLD_BIT]) begin
                cal_state <= CAL_IDLE;
            end else if (setup_wr) begin
                case (wr_mode)
                    ADCSMC_MODE_SELF: cal_state <= CAL_ZERO; // [RULE5] [RULE17]
                    ADCSMC_MODE_ZERO: cal_state <= CAL_ZERO; // [RULE8] [RULE17]
                    ADCSMC_MODE_FULL: cal_state <= CAL_FULL; // [RULE9] [RULE17]
                    default:          cal_state <= CAL_IDLE; // [RULE4]
                endcase
            end else if (hold) begin
                cal_state <= CAL_IDLE; // [RULE13]
            end else if (cal_step_done_i) begin
                case (cal_state)
                    CAL_ZERO: begin
                        if (converter_setup[`ADCSMC_MODE_MSB:`ADCSMC_MODE_LSB]
                                == ADCSMC_MODE_SELF) begin
                            cal_state <= CAL_FULL; // [RULE6]
                        end else begin
                            cal_state <= CAL_IDLE;
                            cal_done  <= 1'b1;
                        end
                    end
                    CAL_FULL: begin
                        cal_state <= CAL_IDLE;
                        cal_done  <= 1'b1;
                    end
                    default: cal_state <= CAL_IDLE;
                endcase
            end
        end
    end

    // Setup register; hardware clears the mode at calibration end.
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            converter_setup <= `ADCSMC_SETUP_RESET; // [RULE2] [RULE3]
        end else if (setup_wr) begin
            converter_setup <= setup_wdata; // [RULE1]
        end else if (cal_done) begin
            converter_setup[`ADCSMC_MODE_MSB:`ADCSMC_MODE_LSB] <= ADCSMC_MODE_NORMAL; // [RULE5]
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Filter settling and data-ready flag.
    logic [1:0] settle_cnt;
    logic       settled;
    logic       new_result;

    // The filter needs three update ticks before a result is trusted.
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            settle_cnt <= 2'h0;
        end else if (hold || (setup_wr && wr_mode != ADCSMC_MODE_NORMAL)) begin
            settle_cnt <= 2'h0; // [RULE13]
        end else if (update_tick_i && settle_cnt != `ADCSMC_SETTLE_PERIODS) begin
            settle_cnt <= settle_cnt + 2'h1; // [RULE14]
        end
    end
    assign settled    = (settle_cnt == `ADCSMC_SETTLE_PERIODS);
    assign new_result = (update_tick_i && settled && cal_state == CAL_IDLE) || cal_done;

    // Flag is active high internally; set by a fresh result, cleared by a
    // calibration start. Hold never raises it, so a low pin stays low.
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            result_pending_flag <= 1'b0;
        end else if (new_result) begin
            result_pending_flag <= 1'b1; // [RULE7] [RULE14]
        end else if (setup_wr && wr_mode != ADCSMC_MODE_NORMAL
                && !setup_wdata[`ADCSMC_HOLD_BIT]) begin
            result_pending_flag <= 1'b0; // [RULE7] [RULE15]
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Registered outputs to the analog front end.
    function automatic logic [7:0] gain_of(input logic [2:0] code);
        gain_of = 8'h01 << code;
    endfunction

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            front_o                 <= '0;
            cal_o                   <= '0;
            convert_run_o           <= 1'b0;
            result_valid_o          <= 1'b0;
            result_pending_flag_n_o <= 1'b1;
        end else begin
            front_o.gain_factor     <= gain_of(converter_setup[`ADCSMC_GAIN_MSB:`ADCSMC_GAIN_LSB]); // [RULE10]
            front_o.unipolar        <= converter_setup[`ADCSMC_POL_BIT]; // [RULE11]
            front_o.buffer_in       <= converter_setup[`ADCSMC_BUF_BIT]; // [RULE12]
            front_o.channel_select  <= channel_select; // [RULE16]
            front_o.noise_test      <= (channel_select == 2'h2); // [RULE16]
            front_o.hold_reset      <= hold; // [RULE13]
            cal_o.busy              <= (cal_state != CAL_IDLE);
            cal_o.zero_scale        <= (cal_state == CAL_ZERO);
            cal_o.full_scale        <= (cal_state == CAL_FULL);
            cal_o.internal_src      <= (converter_setup[`ADCSMC_MODE_MSB:`ADCSMC_MODE_LSB]
                                        == ADCSMC_MODE_SELF); // [RULE6]
            convert_run_o           <= !hold && cal_state == CAL_IDLE; // [RULE4]
            result_valid_o          <= new_result;
            result_pending_flag_n_o <= !result_pending_flag;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks.
    property p_mode_clear;
        cal_done && !setup_wr |=> converter_setup[7:6] == 2'h0;
    endproperty
    a_mode_clear: assert property (p_mode_clear) else $error("mode not cleared"); // [RULE5]
    property p_hold_idle;
        hold && !setup_wr |=> cal_state == CAL_IDLE && settle_cnt == 2'h0;
    endproperty
    a_hold_idle: assert property (p_hold_idle) else $error("hold not honoured"); // [RULE13]
    property p_cal_start;
        setup_wr && setup_wdata[7:6] != 2'h0 && !setup_wdata[0] |=> cal_state != CAL_IDLE;
    endproperty
    a_cal_start: assert property (p_cal_start) else $error("cal not started"); // [RULE17]
    property p_flag_cal;
        setup_wr && setup_wdata[7:6] != 2'h0 && !setup_wdata[0] && !new_result
            |=> ##1 result_pending_flag_n_o;
    endproperty
    a_flag_cal: assert property (p_flag_cal) else $error("flag not raised"); // [RULE7]
    property p_flag_done;
        cal_done |=> ##1 !result_pending_flag_n_o;
    endproperty
    a_flag_done: assert property (p_flag_done) else $error("flag not lowered"); // [RULE7]
    property p_settle;
        $rose(new_result) && !cal_done |-> settle_cnt == 2'h3;
    endproperty
    a_settle: assert property (p_settle) else $error("result before settle"); // [RULE14]
    property p_hold_flag;
        setup_wr && setup_wdata[0] && result_pending_flag |=> result_pending_flag;
    endproperty
    a_hold_flag: assert property (p_hold_flag) else $error("hold cleared flag"); // [RULE15]
    property p_gain;
        $stable(converter_setup) |=> front_o.gain_factor == (8'h01 << $past(converter_setup[5:3]));
    endproperty
    a_gain: assert property (p_gain) else $error("gain mismatch"); // [RULE10]
endmodule

// >>> tb/adcsmc_host_model.sv
// Host side of the three-wire port: drives a framed, idle-high serial clock.
module adcsmc_host_model (
    // Bench clock.
    input  wire logic clk_i,
    // Serial pins of the converter.
    input  wire logic dout_i,
    output logic      sclk_o,
    output logic      din_o,
    output logic      cs_n_o
);
    timeunit 1ns;
    timeprecision 1ps;

    ////////////////////////////////////////////////////////////////////////////
    // The serial clock stands high between frames and the port is deselected.
    initial begin
        sclk_o = 1'b1;
        din_o  = 1'b0;
        cs_n_o = 1'b1;
    end

    ////////////////////////////////////////////////////////////////////////////
    // One byte, MSB first, 200 ns per bit; data changes while the clock is low.
    // The output is sampled just before each falling edge, where it has had
    // a whole high phase to settle after the synchronising flops.
    task automatic shift_byte(input logic [7:0] b, output logic [7:0] got);
        for (int i = 7; i >= 0; i--) begin
            @(posedge clk_i);
            got[i] = dout_i;
            sclk_o <= 1'b0;
            din_o  <= b[i];
            repeat (4) @(posedge clk_i);
            sclk_o <= 1'b1;
            repeat (3) @(posedge clk_i);
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Communications byte, a pause with the clock still, then the data byte.
    task automatic xfer(input logic [7:0] comms, input logic [7:0] data,
                        output logic [7:0] got);
        logic [7:0] unused;
        @(posedge clk_i);
        cs_n_o <= 1'b0;
        repeat (2) @(posedge clk_i);
        shift_byte(comms, unused);
        repeat (8) @(posedge clk_i);
        shift_byte(data, got);
        repeat (4) @(posedge clk_i);
        cs_n_o <= 1'b1;
        din_o  <= ~din_o;
    endtask
endmodule

// >>> tb/test_adc_setup_mode_control.sv
// Self-checking bench of the setup and mode logic.
module test_adc_setup_mode_control;
    timeunit 1ns;
    timeprecision 1ps;
    import adcsmc_pkg::*;

    localparam int LIMIT = 20000;

    logic          clk;
    logic          rst_n;
    logic          update_tick;
    logic          cal_step_done;
    logic          sclk;
    logic          din;
    logic          cs_n;
    logic          dout;
    adcsmc_front_t front;
    adcsmc_cal_t   cal;
    logic          convert_run;
    logic          result_valid;
    logic          flag_n;
    logic [7:0]    got;
    logic [1:0]    ch;
    int            err_total;
    int            n_tests;
    int            cycles;
    int            rv_cnt;
    int            rv0;

    ////////////////////////////////////////////////////////////////////////////
    // Design and host model.
    adcsmc_top i_dut (
        .clk_i                   (clk),
        .rst_n_i                 (rst_n),
        .sclk_i                  (sclk),
        .din_i                   (din),
        .cs_n_i                  (cs_n),
        .dout_o                  (dout),
        .update_tick_i           (update_tick),
        .cal_step_done_i         (cal_step_done),
        .front_o                 (front),
        .cal_o                   (cal),
        .convert_run_o           (convert_run),
        .result_valid_o          (result_valid),
        .result_pending_flag_n_o (flag_n)
    );

    adcsmc_host_model i_host (
        .clk_i  (clk),
        .dout_i (dout),
        .sclk_o (sclk),
        .din_o  (din),
        .cs_n_o (cs_n)
    );

    ////////////////////////////////////////////////////////////////////////////
    // 40 MHz clock.
    always #12.5 clk = ~clk;

    // Result pulses are counted so settling can be judged over many ticks.
    always @(posedge clk) begin
        if (result_valid === 1'b1) rv_cnt++;
    end

    // A hang is cut short and counted as a mismatch.
    always @(posedge clk) begin
        cycles++;
        if (cycles == LIMIT) begin
            err_total++;
            wrap_up();
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_total++;
            $display("Error at time %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask

    // The channel bits ride in every communications byte.
    task automatic wr_setup(input logic [7:0] v);
        logic [7:0] unused;
        i_host.xfer({1'b0, 3'h1, 1'b0, 1'b0, ch}, v, unused);
        repeat (8) @(posedge clk);
    endtask

    task automatic rd_setup(output logic [7:0] v);
        i_host.xfer({1'b0, 3'h1, 1'b1, 1'b0, ch}, 8'hA5, v);
        repeat (8) @(posedge clk);
    endtask

    // One-cycle pulse on the step-done input or the update tick.
    task automatic pulse(input bit step);
        @(posedge clk);
        if (step) cal_step_done <= 1'b1;
        else update_tick <= 1'b1;
        @(posedge clk);
        cal_step_done <= 1'b0;
        update_tick   <= 1'b0;
        repeat (4) @(posedge clk);
    endtask

    task automatic wrap_up();
        $display("Comparisons %0d, mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        clk           = 1'b0;
        rst_n         = 1'b0;
        update_tick   = 1'b0;
        cal_step_done = 1'b0;
        ch            = 2'h2;
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        repeat (8) @(posedge clk);
        rd_setup(got);
        chk(got, 8'h01);
        chk(8'(front.hold_reset), 8'h01);
        chk(8'(convert_run), 8'h00);
        $display("Test reset values done");

        // Every gain code, with polarity and buffer bits toggled against each other.
        for (int g = 0; g < 8; g++) begin
            wr_setup({2'h0, 3'(g), g[0], ~g[0], 1'b0});
            chk(front.gain_factor, 8'h01 << g);
            chk(8'(front.unipolar), 8'(g[0]));
            chk(8'(front.buffer_in), 8'(!g[0]));
        end
        rd_setup(got);
        chk(got, 8'h3C);
        chk(8'(front.channel_select), 8'h02);
        chk(8'(front.noise_test), 8'h01);
        chk(8'(convert_run), 8'h01);
        $display("Test gain and field decoding done");

        // Settling restarts at the hold release: three ticks then a result.
        wr_setup(8'h01);
        wr_setup(8'h00);
        rv0 = rv_cnt;
        repeat (3) pulse(1'b0);
        chk(8'(rv_cnt - rv0), 8'h00);
        pulse(1'b0);
        chk(8'(rv_cnt - rv0), 8'h01);
        chk(8'(flag_n), 8'h00);
        $display("Test filter settling done");

        // Hold keeps the logic reset but leaves a low flag and the port alone.
        wr_setup(8'h01);
        chk(8'(flag_n), 8'h00);
        chk(8'(convert_run), 8'h00);
        rd_setup(got);
        chk(got, 8'h01);
        wr_setup(8'h41);
        chk(8'(cal.busy), 8'h00);
        wr_setup(8'h00);
        $display("Test filter hold done");

        // Each calibration mode, started while conversion runs.
        for (int m = 1; m < 4; m++) begin
            chk(8'(convert_run), 8'h01);
            wr_setup({2'(m), 3'h2, 3'h0});
            chk(8'(flag_n), 8'h01);
            chk(8'(convert_run), 8'h00);
            chk(8'(cal), (m == 1) ? 8'h0D : (m == 2) ? 8'h0C : 8'h0A);
            if (m == 1) begin
                pulse(1'b1);
                chk(8'(cal), 8'h0B);
            end
            pulse(1'b1);
            repeat (4) @(posedge clk);
            chk(8'(flag_n), 8'h00);
            chk(8'(cal.busy), 8'h00);
            rd_setup(got);
            chk(got, 8'h10);
            chk(8'(convert_run), 8'h01);
        end
        $display("Test calibration modes done");

        // A write to another register select leaves the setup alone; new channel.
        ch = 2'h1;
        i_host.xfer({1'b0, 3'h2, 1'b0, 1'b0, ch}, 8'hC3, got);
        repeat (8) @(posedge clk);
        rd_setup(got);
        chk(got, 8'h10);
        chk(8'(front.channel_select), 8'h01);
        chk(8'(front.noise_test), 8'h00);
        $display("Test register select done");
        wrap_up();
    end
endmodule
